// >>> hdl/dhc_coupler_ctrl.sv
// control core of the two-computer coupler: flags, masks, interrupts, packing, status
// assumes inputs from pins are asynchronous; the ten control and strobe pins are synchronised here, code, data and address buses are not;
// strobes from the channels are level requests held until acknowledged
//
// Operation
// - primary code is 4-bit op, 8-bit operand
// - bad parity primary code: no execution, error
// - primary ops set/clear flags or primary mask
// - primary op0 arms/disarms secondary-not-running interrupt
// - primary op0 arms/disarms secondary read/write interrupt
// - mask and flag both one interrupts owner
// - respond only when unit field matches switch
// - direction bit picks data or code/status
// - secondary ops set/clear flags or secondary mask
// - bit0 clears all secondary state and mask
// - bit1 clears selections, responses, packing mode
// - clear first, then apply bits 2-7
// - data interrupt; next data reply drops response
// - transfer_done interrupt on transfer termination
// - alarm interrupt on parity error or not running
// - start input signals primary secondary will read
// - stop transfer signals end, sets done status
// - packing routes primary bits 6-11 to 8-13
// - packing zeroes top two bits per character
// - status word layout, flags in upper byte
// - done sets on read drop or on write drop with buffer empty, clears on start
// - guard accepts only protected instructions except status
`timescale 1ns/1ps
module dhc_coupler_ctrl (
    input wire logic mclk,
    input wire logic rst,
    // primary side
    input wire logic pCodeStrobe,
    input wire logic [11:0] pCode,
    input wire logic pCodeParityOk,
    input wire logic pConnected,
    input wire logic pReading,
    input wire logic pWriting,
    input wire logic pRunning,
    input wire logic pParityErr,
    input wire logic pDataValid,
    input wire logic [11:0] pData,
    output logic pDataReady,
    output logic pReply,
    output logic pReject,
    output logic pParityErrOut,
    output logic pInterrupt,
    output logic pSecReadSignal,
    output logic pStopSignal,
    // secondary side
    input wire logic sRequest,
    input wire logic sZeroSelect,
    input wire logic [10:0] sAddr,
    input wire logic sIsOutput,
    input wire logic sProtect,
    input wire logic [15:0] sWriteData,
    input wire logic sRunning,
    input wire logic [3:0] unitSwitch,
    input wire logic guardSwitch,
    output logic sReply,
    output logic sReject,
    output logic [15:0] sReadData,
    output logic sInterrupt,
    output logic sReadingOut,
    output logic sWritingOut,
    output logic sDataOutValid,
    output logic [15:0] sDataOut,
    input wire logic sDataOutReady
);
    // ------------------------------------------------------------
    // synchronisers for pin inputs
    // ------------------------------------------------------------
    localparam int NSYNC = 10;
    logic [NSYNC-1:0] syncIn, sync1Q, sync2Q;
    assign syncIn = {pCodeStrobe, pReading, pWriting, pRunning, pParityErr, sRequest, sRunning,
                     guardSwitch, pConnected, pDataValid};
    always_ff @(posedge mclk) begin
        if (rst) begin
            sync1Q <= '0;
            sync2Q <= '0;
        end else begin
            sync1Q <= syncIn;
            sync2Q <= sync1Q;
        end
    end
    logic pStrobeS, pReadS, pWriteS, pRunS, pPerrS, sReqS, sRunS, guardS, pConnS, pDValS;
    assign {pStrobeS, pReadS, pWriteS, pRunS, pPerrS, sReqS, sRunS, guardS, pConnS, pDValS} = sync2Q;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] flags;
        logic [7:0] pMask;
        logic [7:0] sMask;
        logic armNrun;
        logic armRw;
        logic dataSel;
        logic eopSel;
        logic alarmSel;
        logic dataResp;
        logic eopResp;
        logic alarmResp;
        logic pack;
        logic done;
        logic secRead;
        logic secWrite;
        logic pStrobeSeen;
        logic sReqSeen;
        logic pRead1;
        logic pWrite1;
        logic pReply;
        logic pReject;
        logic pPerrOut;
        logic pInt;
        logic pStop;
        logic sReply;
        logic sReject;
        logic [15:0] sReadData;
        logic sInt;
    } dhc_state_type;
    dhc_state_type s_q, s_d;

    // ------------------------------------------------------------
    // code decoders and data buffer
    // ------------------------------------------------------------
    logic pExec, sExec;
    logic [7:0] pFs, pFc, pMs, pMc, pN, sFs, sFc, sMs, sMc, sN;
    logic pMisc, sMisc;
    dhc_code_decode u_pdec (
        .strobe(pExec),
        .code(pCode),
        .flagSet(pFs),
        .flagClr(pFc),
        .maskSet(pMs),
        .maskClr(pMc),
        .miscValid(pMisc),
        .operand(pN)
    );
    dhc_code_decode u_sdec (
        .strobe(sExec),
        .code(sWriteData[dhc_pkg::CODE_W-1:0]),
        .flagSet(sFs),
        .flagClr(sFc),
        .maskSet(sMs),
        .maskClr(sMc),
        .miscValid(sMisc),
        .operand(sN)
    );

    // packing: each 6-bit character lands in the low bits of an 8-bit lane
    function automatic logic [15:0] route_data(input logic [11:0] d, input logic pk);
        logic [15:0] r;
        r = {4'h0, d};
        if (pk) begin
            r = '0;
            r[dhc_pkg::CHAR_LO-1:0] = d[dhc_pkg::CHAR_LO-1:0];
            r[dhc_pkg::PACK_HI_LSB +: dhc_pkg::CHAR_LO] = d[dhc_pkg::PDATA_W-1:dhc_pkg::CHAR_LO];
        end
        return r;
    endfunction : route_data

    logic bufInReady, bufEmpty, bufFlush;
    dhc_skid_buf u_buf (
        .mclk(mclk),
        .rst(rst),
        .flush(bufFlush),
        .inValid(pDValS && pConnS),
        .inReady(bufInReady),
        .inData(route_data(pData, s_q.pack)),
        .outValid(sDataOutValid),
        .outReady(sDataOutReady),
        .outData(sDataOut),
        .empty(bufEmpty)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic unitHit, dirBit, accept, secData, newReq;
    logic [7:0] sN2;
    always_comb begin
        s_d = s_q;
        sN2 = sN;
        // bad parity blocks execution and the reply, and raises the parity error
        pExec = pStrobeS && !s_q.pStrobeSeen && pConnS && pCodeParityOk;
        s_d.pStrobeSeen = pStrobeS;
        s_d.pReply = pExec;
        s_d.pReject = 1'b0;
        s_d.pPerrOut = pStrobeS && !s_q.pStrobeSeen && pConnS && !pCodeParityOk;
        // secondary addressing
        newReq = sReqS && !s_q.sReqSeen;
        s_d.sReqSeen = sReqS;
        unitHit = sZeroSelect && (sAddr[dhc_pkg::UNIT_LSB +: dhc_pkg::UNIT_W] == unitSwitch);
        dirBit = sAddr[dhc_pkg::DIR_BIT];
        accept = newReq && unitHit && (!guardS || sProtect || (dirBit && !sIsOutput));
        sExec = accept && dirBit && sIsOutput;
        secData = accept && !dirBit;
        s_d.sReply = accept;
        s_d.sReject = newReq && unitHit && !accept;
        if (accept && dirBit && !sIsOutput) begin
            s_d.sReadData = {s_q.flags, guardS, pRunS, pPerrS, s_q.done, !bufEmpty, s_q.sInt, pWriteS,
                             pReadS};
        end else if (secData && !sIsOutput) begin
            s_d.sReadData = sDataOut;
        end
        // flags: both sides at once, set wins
        s_d.flags = (s_q.flags & ~(pFc | sFc)) | pFs | sFs;
        s_d.pMask = (s_q.pMask & ~pMc) | pMs;
        if (pMisc) begin
            if (pN == dhc_pkg::PN_ARM_NRUN) s_d.armNrun = 1'b1;
            if (pN == dhc_pkg::PN_DIS_NRUN) s_d.armNrun = 1'b0;
            if (pN == dhc_pkg::PN_ARM_RW) s_d.armRw = 1'b1;
            if (pN == dhc_pkg::PN_DIS_RW) s_d.armRw = 1'b0;
        end
        if (!sMisc) sN2 = '0;
        s_d.sMask = (s_q.sMask & ~sMc) | sMs;
        // clears first, then bits 2-7
        if (sN2[dhc_pkg::SB_CLEAR]) begin
            s_d.sMask = dhc_pkg::MASK_RST;
            s_d.done = 1'b0;
            s_d.secRead = 1'b0;
            s_d.secWrite = 1'b0;
        end
        if (sN2[dhc_pkg::SB_CLEAR] || sN2[dhc_pkg::SB_CLRINT]) begin
            {s_d.dataSel, s_d.eopSel, s_d.alarmSel} = 3'h0;
            {s_d.dataResp, s_d.eopResp, s_d.alarmResp} = 3'h0;
            s_d.pack = 1'b0;
        end
        if (sN2[dhc_pkg::SB_DATA_INT]) s_d.dataSel = 1'b1;
        if (sN2[dhc_pkg::SB_EOP_INT]) s_d.eopSel = 1'b1;
        if (sN2[dhc_pkg::SB_ALARM_INT]) s_d.alarmSel = 1'b1;
        if (sN2[dhc_pkg::SB_PACK]) s_d.pack = 1'b1;
        if (sN2[dhc_pkg::SB_START_IN]) begin
            s_d.secRead = 1'b1;
            s_d.done = 1'b0;
        end
        if (secData && sIsOutput && !s_q.secWrite) begin
            s_d.secWrite = 1'b1;
            s_d.done = 1'b0;
        end
        s_d.pStop = sN2[dhc_pkg::SB_STOP];
        if (sN2[dhc_pkg::SB_STOP]) begin
            s_d.secRead = 1'b0;
            s_d.secWrite = 1'b0;
            s_d.done = 1'b1;
        end
        // done on any read drop or write drop with buffer empty
        s_d.pRead1 = pReadS;
        s_d.pWrite1 = pWriteS;
        if ((s_q.pRead1 && !pReadS) || (s_q.pWrite1 && !pWriteS && bufEmpty)) s_d.done = 1'b1;
        // responses; a same-cycle bit0/bit1 clear beats a new event unless bits 2-4 reselect, a data reply beats a new data event
        if (s_d.dataSel && (sDataOutValid || bufInReady)) s_d.dataResp = 1'b1;
        if (secData) s_d.dataResp = 1'b0;
        if (s_d.eopSel && s_d.done && !s_q.done) s_d.eopResp = 1'b1;
        if (s_d.alarmSel && (pPerrS || !pRunS)) s_d.alarmResp = 1'b1;
        s_d.sInt = s_q.dataResp || s_q.eopResp || s_q.alarmResp || |(s_q.sMask & s_q.flags);
        s_d.pInt = |(s_q.pMask & s_q.flags) || (s_q.armNrun && !sRunS)
                   || (s_q.armRw && (s_q.secRead || s_q.secWrite));
        bufFlush = sN2[dhc_pkg::SB_CLEAR];
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s_q <= '0;
            s_q.flags <= dhc_pkg::FLAGS_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign pDataReady = bufInReady;
    assign pReply = s_q.pReply;
    assign pReject = s_q.pReject;
    assign pParityErrOut = s_q.pPerrOut;
    assign pInterrupt = s_q.pInt;
    assign pSecReadSignal = s_q.secRead;
    assign pStopSignal = s_q.pStop;
    assign sReply = s_q.sReply;
    assign sReject = s_q.sReject;
    assign sReadData = s_q.sReadData;
    assign sInterrupt = s_q.sInt;
    assign sReadingOut = s_q.secRead;
    assign sWritingOut = s_q.secWrite;
endmodule : dhc_coupler_ctrl

// >>> hdl/dhc_pkg.sv
// shared constants of the dual host coupler control
// assumes one system clock; no other package is needed
package dhc_pkg;
    // ------------------------------------------------------------
    // function code layout
    // ------------------------------------------------------------
    localparam int CODE_W = 12;
    localparam int OP_LSB = 8;
    localparam int OP_W = 4;
    localparam int N_W = 8;
    localparam logic [3:0] OP_MISC = 4'h0;
    localparam logic [3:0] OP_SET_FLAG = 4'h1;
    localparam logic [3:0] OP_CLR_FLAG = 4'h2;
    localparam logic [3:0] OP_SET_MASK = 4'h4;
    localparam logic [3:0] OP_CLR_MASK = 4'h8;
    // primary op zero operands
    localparam logic [7:0] PN_ARM_NRUN = 8'h01;
    localparam logic [7:0] PN_DIS_NRUN = 8'h02;
    localparam logic [7:0] PN_ARM_RW = 8'h04;
    localparam logic [7:0] PN_DIS_RW = 8'h08;
    // secondary op zero bit positions
    localparam int SB_CLEAR = 0;
    localparam int SB_CLRINT = 1;
    localparam int SB_DATA_INT = 2;
    localparam int SB_EOP_INT = 3;
    localparam int SB_ALARM_INT = 4;
    localparam int SB_START_IN = 5;
    localparam int SB_STOP = 6;
    localparam int SB_PACK = 7;
    // ------------------------------------------------------------
    // secondary address word layout
    // ------------------------------------------------------------
    localparam int ADDR_W = 11;
    localparam int DIR_BIT = 0;
    localparam int UNIT_LSB = 7;
    localparam int UNIT_W = 4;
    // ------------------------------------------------------------
    // peer_status_word bit positions
    // ------------------------------------------------------------
    localparam int ST_P_READ = 0;
    localparam int ST_P_WRITE = 1;
    localparam int ST_INT = 2;
    localparam int ST_DATA = 3;
    localparam int ST_DONE = 4;
    localparam int ST_PERR = 5;
    localparam int ST_P_RUN = 6;
    localparam int ST_GUARD = 7;
    localparam int ST_FLAG_LSB = 8;
    localparam int WORD_W = 16;
    localparam int PDATA_W = 12;
    localparam int CHAR_LO = 6;
    localparam int PACK_HI_LSB = 8;
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam int BUF_DEPTH = 2;
endpackage : dhc_pkg

// >>> hdl/dhc_code_decode.sv
// decoder for one 12-bit function code into flag and mask set/clear vectors
// assumes the code is qualified by a one-cycle strobe on the same clock
`timescale 1ns/1ps
module dhc_code_decode (
    input wire logic strobe,
    input wire logic [11:0] code,
    output logic [7:0] flagSet,
    output logic [7:0] flagClr,
    output logic [7:0] maskSet,
    output logic [7:0] maskClr,
    output logic miscValid,
    output logic [7:0] operand
);
    logic [3:0] op;
    always_comb begin
        op = code[dhc_pkg::OP_LSB +: dhc_pkg::OP_W];
        operand = code[dhc_pkg::N_W-1:0];
        flagSet = '0;
        flagClr = '0;
        maskSet = '0;
        maskClr = '0;
        miscValid = 1'b0;
        // unknown op values fall through with all set/clear vectors and miscValid zero
        if (strobe) begin
            case (op)
                dhc_pkg::OP_SET_FLAG: flagSet = operand;
                dhc_pkg::OP_CLR_FLAG: flagClr = operand;
                dhc_pkg::OP_SET_MASK: maskSet = operand;
                dhc_pkg::OP_CLR_MASK: maskClr = operand;
                dhc_pkg::OP_MISC: miscValid = 1'b1;
                default: miscValid = 1'b0;
            endcase
        end
    end
endmodule : dhc_code_decode

// >>> hdl/dhc_skid_buf.sv
// two-entry buffer with valid/ready on both sides
// assumes a single clock and synchronous active-high reset
`timescale 1ns/1ps
module dhc_skid_buf (
    input wire logic mclk,
    input wire logic rst,
    input wire logic flush,
    input wire logic inValid,
    output logic inReady,
    input wire logic [15:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [15:0] outData,
    output logic empty
);
    typedef struct packed {
        logic [1:0][15:0] mem;
        logic rdIdx;
        logic wrIdx;
        logic [1:0] count;
    } dhc_buf_type;
    dhc_buf_type s_q, s_d;
    logic doWr, doRd;
    always_comb begin
        doWr = inValid && (s_q.count != 2'(dhc_pkg::BUF_DEPTH));
        doRd = outReady && (s_q.count != 2'h0);
        s_d = s_q;
        if (doWr) begin
            s_d.mem[s_q.wrIdx] = inData;
            s_d.wrIdx = ~s_q.wrIdx;
        end
        if (doRd) begin
            s_d.rdIdx = ~s_q.rdIdx;
        end
        s_d.count = 2'(s_q.count + {1'b0, doWr} - {1'b0, doRd});
        if (flush) begin
            s_d.rdIdx = 1'b0;
            s_d.wrIdx = 1'b0;
            s_d.count = 2'h0;
        end
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign inReady = (s_q.count != 2'(dhc_pkg::BUF_DEPTH));
    assign outValid = (s_q.count != 2'h0);
    assign outData = s_q.mem[s_q.rdIdx];
    assign empty = (s_q.count == 2'h0);
endmodule : dhc_skid_buf

// >>> test/dhc_coupler_ctrl_chk.sv
// port checker of the coupler control core
// bound to every dhc_coupler_ctrl; one clock mclk, rst sync high
`timescale 1ns/1ps
module dhc_coupler_ctrl_chk (
    input wire logic mclk,
    input wire logic rst,
    input wire logic pCodeStrobe,
    input wire logic pCodeParityOk,
    input wire logic pConnected,
    input wire logic pReply,
    input wire logic pReject,
    input wire logic pParityErrOut,
    input wire logic pStopSignal,
    input wire logic sRequest,
    input wire logic sZeroSelect,
    input wire logic [10:0] sAddr,
    input wire logic sIsOutput,
    input wire logic sProtect,
    input wire logic [3:0] unitSwitch,
    input wire logic guardSwitch,
    input wire logic sReply,
    input wire logic sReject,
    input wire logic sDataOutValid,
    input wire logic [15:0] sDataOut,
    input wire logic sDataOutReady
);
    // ------------------------------------------------------------
    // relations
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    sequence s_bad_code;
        $rose(pCodeStrobe) && pConnected && !pCodeParityOk;
    endsequence
    sequence s_err_back;
        ##[1:6] pParityErrOut;
    endsequence
    property p_bad_parity; s_bad_code |-> s_err_back; endproperty
    a_bad_parity: assert property (p_bad_parity) else $error("bad parity code not flagged");
    property p_err_excl; pParityErrOut |-> !pReply; endproperty
    a_err_excl: assert property (p_err_excl) else $error("reply beside parity error");
    property p_reject_off; !pReject; endproperty
    a_reject_off: assert property (p_reject_off) else $error("primary reject raised");
    property p_unit; (sReply || sReject) |-> sZeroSelect && sAddr[10:7] == unitSwitch; endproperty
    a_unit: assert property (p_unit) else $error("answer to foreign unit");
    property p_guard; sReject |-> guardSwitch && !sProtect && !(sAddr[0] && !sIsOutput); endproperty
    a_guard: assert property (p_guard) else $error("reject without guard cause");
    property p_status_ok; sReply && guardSwitch && !sProtect |-> sAddr[0] && !sIsOutput; endproperty
    a_status_ok: assert property (p_status_ok) else $error("unprotected access accepted");
    property p_stop; pStopSignal |-> sRequest && sIsOutput && sAddr[0]; endproperty
    a_stop: assert property (p_stop) else $error("stop signal without code");
    property p_pack_top; sDataOutValid |-> sDataOut[15:14] == 2'h0; endproperty
    a_pack_top: assert property (p_pack_top) else $error("top character bits not zero");
    // a stalled word must not change, or the receiver loses it
    property p_hold; sDataOutValid && !sDataOutReady |=> sDataOutValid && $stable(sDataOut); endproperty
    a_hold: assert property (p_hold) else $error("stalled word changed");
endmodule : dhc_coupler_ctrl_chk

bind dhc_coupler_ctrl dhc_coupler_ctrl_chk u_dhc_coupler_ctrl_chk (.mclk, .rst, .pCodeStrobe, .pCodeParityOk,
    .pConnected, .pReply, .pReject, .pParityErrOut, .pStopSignal, .sRequest, .sZeroSelect, .sAddr, .sIsOutput,
    .sProtect, .unitSwitch, .guardSwitch, .sReply, .sReject, .sDataOutValid, .sDataOut, .sDataOutReady);

// >>> test/dhc_host_model.sv
// secondary host model: issues instructions, sinks the data stream
// faces the secondary side of dhc_coupler_ctrl; the bench calls sec_op
`timescale 1ns/1ps
module dhc_host_model (
    input wire logic mclk,
    input wire logic stall,
    output logic sRequest,
    output logic sZeroSelect,
    output logic [10:0] sAddr,
    output logic sIsOutput,
    output logic sProtect,
    output logic [15:0] sWriteData,
    input wire logic sReply,
    input wire logic sReject,
    input wire logic [15:0] sReadData,
    input wire logic sDataOutValid,
    input wire logic [15:0] sDataOut,
    output logic sDataOutReady
);
    logic [15:0] rxq[$];
    initial begin
        sRequest = 1'b0;
        sZeroSelect = 1'b1;
        sAddr = 11'h000;
        sIsOutput = 1'b0;
        sProtect = 1'b0;
        sWriteData = 16'h0000;
    end
    assign sDataOutReady = !stall;
    always @(posedge mclk) begin
        if (sDataOutValid === 1'b1 && sDataOutReady) begin
            rxq.push_back(sDataOut);
        end
    end
    // ------------------------------------------------------------
    // one instruction; held until answered or 12 cycles pass
    // ------------------------------------------------------------
    task automatic sec_op(input logic isOut, input logic dir, input logic prot, input logic [3:0] unit,
        input logic [15:0] d, output logic [1:0] ans, output logic [15:0] rd);
        int n;
        ans = 2'h0;
        rd = 16'h0000;
        @(posedge mclk);
        #1;
        sRequest = 1'b1;
        sAddr = {unit, 6'h00, dir};
        sIsOutput = isOut;
        sProtect = prot;
        sWriteData = d;
        // look just after the edge; hold through the edge that samples the answer
        for (n = 0; n < 12 && ans === 2'h0; n++) begin
            @(posedge mclk);
            #1;
            ans = {sReject, sReply};
            rd = sReadData;
        end
        @(posedge mclk);
        #1;
        sRequest = 1'b0;
        // released lines must not keep the old value
        sAddr = ~sAddr;
        sWriteData = ~sWriteData;
        repeat (3) @(posedge mclk);
    endtask : sec_op
endmodule : dhc_host_model

// >>> test/dhc_coupler_ctrl_bench.sv
// self-checking bench of dhc_coupler_ctrl with the secondary host model
// one clock mclk at 200 MHz; design and model compiled first
`timescale 1ns/1ps
module dhc_coupler_ctrl_bench;
    localparam logic [3:0] UNIT = 4'ha;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic pCodeStrobe = 1'b0;
    logic [11:0] pCode = 12'h000;
    logic pCodeParityOk = 1'b1;
    logic pConnected = 1'b1;
    logic pRunning = 1'b1;
    logic pDataValid = 1'b0;
    logic [11:0] pData = 12'h000;
    logic guardSwitch = 1'b0;
    logic stall = 1'b0;
    logic stopSeen = 1'b0;
    logic pDataReady, pReply, pReject, pParityErrOut, pInterrupt, pSecReadSignal, pStopSignal;
    logic sRequest, sZeroSelect, sIsOutput, sProtect, sReply, sReject, sInterrupt;
    logic sReadingOut, sWritingOut, sDataOutValid, sDataOutReady;
    logic [10:0] sAddr;
    logic [15:0] sWriteData, sReadData, sDataOut, rd;
    logic [1:0] ans;
    logic r, e;
    int fail_count = 0;
    int checks_done = 0;
    always #2.5 mclk = ~mclk;
    always @(posedge mclk) if (pStopSignal === 1'b1) stopSeen <= 1'b1;
    dhc_coupler_ctrl u_dhc_coupler_ctrl (.mclk, .rst, .pCodeStrobe, .pCode, .pCodeParityOk, .pConnected,
        .pReading(1'b0), .pWriting(1'b0), .pRunning, .pParityErr(1'b0), .pDataValid, .pData, .pDataReady,
        .pReply, .pReject, .pParityErrOut, .pInterrupt, .pSecReadSignal, .pStopSignal, .sRequest, .sZeroSelect,
        .sAddr, .sIsOutput, .sProtect, .sWriteData, .sRunning(1'b1), .unitSwitch(UNIT), .guardSwitch, .sReply,
        .sReject, .sReadData, .sInterrupt, .sReadingOut, .sWritingOut, .sDataOutValid, .sDataOut, .sDataOutReady);
    dhc_host_model u_dhc_host_model (.mclk, .stall, .sRequest, .sZeroSelect, .sAddr, .sIsOutput, .sProtect,
        .sWriteData, .sReply, .sReject, .sReadData, .sDataOutValid, .sDataOut, .sDataOutReady);
    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic p_code(input logic [11:0] c, input logic ok);
        int n;
        r = 1'b0;
        e = 1'b0;
        @(posedge mclk);
        #1;
        pCode = c;
        pCodeParityOk = ok;
        pCodeStrobe = 1'b1;
        for (n = 0; n < 12 && r !== 1'b1 && e !== 1'b1; n++) begin
            @(posedge mclk);
            #1;
            r = pReply;
            e = pParityErrOut;
        end
        @(posedge mclk);
        #1;
        pCodeStrobe = 1'b0;
        repeat (3) @(posedge mclk);
    endtask : p_code
    // one-cycle offer: taken once whether the pin is edge or level read
    task automatic p_word(input logic [11:0] w);
        @(posedge mclk);
        #1;
        pData = w;
        pDataValid = 1'b1;
        @(posedge mclk);
        #1;
        pDataValid = 1'b0;
        repeat (3) @(posedge mclk);
    endtask : p_word
    task automatic sec(input logic [15:0] d);
        u_dhc_host_model.sec_op(1'b1, 1'b1, 1'b1, UNIT, d, ans, rd);
        repeat (3) @(posedge mclk);
    endtask : sec
    task automatic stat(input logic [15:0] exp);
        u_dhc_host_model.sec_op(1'b0, 1'b1, 1'b1, UNIT, 16'h0000, ans, rd);
        chk("status", exp, rd);
    endtask : stat
    task automatic tally_and_finish;
        if (fail_count == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge mclk);
        #1;
        rst = 1'b0;
        repeat (2) @(posedge mclk);
        stat(16'h0040);
        p_code(12'h15a, 1'b1);
        chk("pReply", 16'h0001, 16'(r));
        p_code(12'h1ff, 1'b0);
        chk("pParityErrOut", 16'h0001, 16'(e));
        chk("pReply", 16'h0000, 16'(r));
        p_code(12'h3ff, 1'b1);
        pConnected = 1'b0;
        repeat (3) @(posedge mclk);
        p_code(12'h1ff, 1'b1);
        pConnected = 1'b1;
        repeat (3) @(posedge mclk);
        stat(16'h5a40);
        p_code(12'h402, 1'b1);
        repeat (3) @(posedge mclk);
        chk("pInterrupt", 16'h0001, 16'(pInterrupt));
        sec(16'h0480);
        chk("sInterrupt", 16'h0000, 16'(sInterrupt));
        sec(16'h0180);
        chk("sInterrupt", 16'h0001, 16'(sInterrupt));
        sec(16'h0009);
        chk("sInterrupt", 16'h0000, 16'(sInterrupt));
        sec(16'h0040);
        chk("pStopSignal", 16'h0001, 16'(stopSeen));
        chk("sInterrupt", 16'h0001, 16'(sInterrupt));
        stat(16'hda54);
        sec(16'h0020);
        chk("pSecReadSignal", 16'h0001, 16'(pSecReadSignal));
        u_dhc_host_model.sec_op(1'b1, 1'b0, 1'b1, UNIT, 16'h0123, ans, rd);
        chk("sWritingOut", 16'h0001, 16'(sWritingOut));
        u_dhc_host_model.sec_op(1'b0, 1'b1, 1'b1, UNIT ^ 4'h1, 16'h0000, ans, rd);
        chk("foreign unit", 16'h0000, 16'(ans));
        guardSwitch = 1'b1;
        repeat (4) @(posedge mclk);
        u_dhc_host_model.sec_op(1'b1, 1'b1, 1'b0, UNIT, 16'h0180, ans, rd);
        chk("guarded code", 16'h0002, 16'(ans));
        u_dhc_host_model.sec_op(1'b0, 1'b1, 1'b0, UNIT, 16'h0000, ans, rd);
        chk("guarded status", 16'h0001, 16'(ans));
        chk("guard bit", 16'h0080, rd & 16'h0080);
        guardSwitch = 1'b0;
        sec(16'h0080);
        stall = 1'b1;
        p_word(12'hfc3);
        p_word(12'hfc3);
        chk("pDataReady", 16'h0000, 16'(pDataReady));
        stall = 1'b0;
        repeat (6) @(posedge mclk);
        chk("words", 16'h0002, 16'(u_dhc_host_model.rxq.size()));
        chk("packed", 16'h3f03, u_dhc_host_model.rxq[1]);
        sec(16'h0002);
        p_word(12'h5a5);
        repeat (6) @(posedge mclk);
        chk("unpacked", 16'h05a5, u_dhc_host_model.rxq[2]);
        tally_and_finish();
    end
    initial begin
        #40000;
        fail_count++;
        tally_and_finish();
    end
endmodule : dhc_coupler_ctrl_bench
